/* File: buck_fault_hiccup_sequencer.sv */
`timescale 1ns/1ps
module buck_fault_hiccup_sequencer
  import buck_seq_pkg::*;
#(
  parameter int SW_PERIOD_CYC = SW_PERIOD_CYC_DEF,
  parameter int SS_CYC        = SS_CYC_DEF,
  parameter int RST_CYC       = RST_CYC_DEF,
  parameter int BOOT_CYC      = BOOT_CYC_DEF,
  parameter int VALID_CYC     = VALID_DLY_CYC
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rstn,
  input  wire analog_in_t i_analog,
  output gate_t           o_gate,
  output logic            o_output_valid_flag,
  output logic            o_ref_zero,
  output logic            o_soft_start,
  output logic            o_hiccup
);

  localparam int DUTY_CYC = SW_PERIOD_CYC * DUTY_MAX_PCT / 100;

  analog_in_t sync_a;
  analog_in_t sync_b;
  seq_state_t state;
  seq_state_t next_state;
  logic [15:0] period_cnt;
  logic [31:0] state_cnt;
  logic [31:0] state_lim;
  logic [31:0] win_cnt;
  logic [15:0] uv_cnt;
  logic [15:0] ov_cnt;
  logic [15:0] neg_cnt;
  logic [3:0]  hs_cnt;
  logic [3:0]  ls_cnt;
  logic [3:0]  fault_mult;
  logic [3:0]  hiccup_left;
  logic        on_done;
  logic        hs_hit;
  logic        ls_hit;
  logic        skip;
  logic        ovp_mode;
  logic        valid;
  logic        guard;
  logic        period_end;
  logic        timer_done;
  logic        hs_ev;
  logic        ls_ev;
  logic        hs_trip;
  logic        ls_trip;
  logic        uv_trip;
  logic        ov_trip;
  logic        next_hs;
  logic        next_ls;
  logic        next_ovp;

  // Analog comparators are asynchronous to the switching clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= i_analog;
      sync_b <= sync_a;
    end
  end

  assign guard      = (state == ST_SOFT) || (state == ST_RUN);
  assign period_end = (period_cnt == 16'(SW_PERIOD_CYC - 1));
  assign hs_ev      = hs_hit | (guard & sync_b.hs_limit);
  assign ls_ev      = ls_hit | (guard & sync_b.ls_limit);
  assign hs_trip    = guard && period_end && hs_ev && ((hs_cnt + OC_ADD) >= HS_OC_TRIP);
  assign ls_trip    = guard && period_end && ls_ev && ((ls_cnt + OC_ADD) >= LS_OC_TRIP);
  assign uv_trip    = guard && valid && sync_b.fb_under && (uv_cnt == 16'(UV_FILT_CYC - 1));
  assign ov_trip    = guard && sync_b.fb_over && (ov_cnt == 16'(OV_FILT_CYC - 1));

  always_comb begin
    unique case (state)
      ST_RST:  state_lim = 32'(RST_CYC);
      ST_BOOT: state_lim = 32'(BOOT_CYC);
      default: state_lim = 32'(SS_CYC);
    endcase
  end
  assign timer_done = (state_cnt == state_lim - 32'h1);

  always_comb begin
    next_state = state;
    if (!sync_b.enable) begin
      next_state = ST_OFF;
    end else if (!sync_b.supply_ok && state != ST_OFF) begin
      next_state = ST_LOCKOUT;
    end else begin
      unique case (state)
        ST_OFF:     if (sync_b.supply_ok) next_state = ST_RST;
        ST_LOCKOUT: next_state = ST_BOOT;
        ST_RST:     if (timer_done) next_state = ST_SOFT;
        ST_BOOT:    if (timer_done) next_state = ST_SOFT;
        ST_SOFT, ST_RUN: begin
          if (sync_b.over_temp) begin
            next_state = ST_THERMAL;
          end else if (ov_trip) begin
            next_state = ST_HICCUP;
          end else if (hs_trip || ls_trip || uv_trip) begin
            next_state = ST_DRAIN;
          end else if (state == ST_SOFT && timer_done) begin
            next_state = ST_RUN;
          end
        end
        ST_DRAIN:   if (sync_b.zero_current) next_state = ST_HICCUP;
        ST_HICCUP: begin
          if (hiccup_left == 4'h1 && timer_done) next_state = ST_BOOT;
        end
        ST_THERMAL: if (sync_b.temp_recovered) next_state = ST_SOFT;
        default:    next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state <= ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Timer restarts on every state change; in hiccup it wraps each soft-start duration
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      state_cnt   <= '0;
      hiccup_left <= '0;
    end else begin
      if (next_state != state || timer_done) begin
        state_cnt <= '0;
      end else begin
        state_cnt <= state_cnt + 32'h1;
      end
      if (next_state == ST_HICCUP && state != ST_HICCUP) begin
        hiccup_left <= (state == ST_DRAIN) ? fault_mult : HICCUP_OV;
      end else if (state == ST_HICCUP && timer_done) begin
        hiccup_left <= hiccup_left - 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      fault_mult <= HICCUP_UV;
    end else if (guard) begin
      if (hs_trip) fault_mult <= HICCUP_HS;
      else if (ls_trip) fault_mult <= HICCUP_LS;
      else if (uv_trip) fault_mult <= HICCUP_UV;
    end
  end

  // Free-running period counter: the fixed internal switching clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      period_cnt <= '0;
    end else if (period_end) begin
      period_cnt <= '0;
    end else begin
      period_cnt <= period_cnt + 16'h1;
    end
  end

  // Per-period events; an event in the last cycle still counts for that period
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      on_done <= 1'b0;
      hs_hit  <= 1'b0;
      ls_hit  <= 1'b0;
      skip    <= 1'b0;
    end else if (period_end) begin
      on_done <= 1'b0;
      hs_hit  <= 1'b0;
      ls_hit  <= 1'b0;
      skip    <= guard & ls_ev;
    end else begin
      on_done <= on_done | sync_b.pwm_off | sync_b.hs_limit;
      hs_hit  <= hs_ev;
      ls_hit  <= ls_ev;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || !guard) begin
      hs_cnt <= '0;
      ls_cnt <= '0;
    end else if (period_end) begin
      if (hs_ev) begin
        hs_cnt <= hs_trip ? 4'h0 : hs_cnt + OC_ADD;
      end else if (!ls_ev && hs_cnt != 4'h0) begin
        hs_cnt <= hs_cnt - OC_SUB;
      end
      if (ls_ev) begin
        ls_cnt <= ls_trip ? 4'h0 : ls_cnt + OC_ADD;
      end else if (!skip && ls_cnt != 4'h0) begin
        ls_cnt <= ls_cnt - OC_SUB;
      end
    end
  end

  // Comparator filters need an unbroken run of the condition
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      uv_cnt  <= '0;
      ov_cnt  <= '0;
      win_cnt <= '0;
    end else begin
      uv_cnt  <= (guard && valid && sync_b.fb_under && !uv_trip) ? uv_cnt + 16'h1 : 16'h0;
      ov_cnt  <= (guard && sync_b.fb_over && !ov_trip) ? ov_cnt + 16'h1 : 16'h0;
      win_cnt <= (guard && sync_b.fb_in_window && !valid) ? win_cnt + 32'h1 : 32'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      valid <= 1'b0;
    end else if (ov_trip || !(guard || state == ST_DRAIN)) begin
      valid <= 1'b0;
    end else if (state == ST_DRAIN && sync_b.zero_current) begin
      valid <= 1'b0;
    end else if (guard && win_cnt == 32'(VALID_CYC - 1) && sync_b.fb_in_window) begin
      valid <= 1'b1;
    end
  end

  assign next_ovp = ov_trip | (ovp_mode & (state == ST_HICCUP));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ovp_mode <= 1'b0;
      neg_cnt  <= '0;
    end else begin
      ovp_mode <= next_ovp;
      if (ovp_mode && sync_b.ls_neg_limit && neg_cnt == 16'h0) begin
        neg_cnt <= 16'(NEG_HOLD_CYC);
      end else if (neg_cnt != 16'h0) begin
        neg_cnt <= neg_cnt - 16'h1;
      end
    end
  end

  always_comb begin
    next_hs = guard && !ov_trip && !sync_b.over_temp && !skip && !on_done && !period_end
      && !sync_b.pwm_off && !sync_b.hs_limit
      && (period_cnt < 16'(DUTY_CYC - 1));
    unique case (state)
      ST_SOFT, ST_RUN: next_ls = ov_trip || (!next_hs && !sync_b.over_temp);
      ST_BOOT:         next_ls = 1'b1;
      ST_DRAIN:        next_ls = !sync_b.zero_current;
      ST_HICCUP:       next_ls = ovp_mode && neg_cnt == 16'h0 && !sync_b.ls_neg_limit && sync_b.fb_over;
      default:         next_ls = 1'b0;
    endcase
    if (next_state == ST_OFF || next_state == ST_LOCKOUT || next_state == ST_THERMAL) begin
      next_hs = 1'b0;
      next_ls = 1'b0;
    end
    if (next_state == ST_DRAIN || next_state == ST_HICCUP) begin
      next_hs = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_gate       <= '0;
      o_ref_zero   <= 1'b0;
      o_soft_start <= 1'b0;
      o_hiccup     <= 1'b0;
    end else begin
      o_gate.hs_on <= next_hs;
      o_gate.ls_on <= next_ls;
      o_ref_zero   <= next_ovp;
      o_soft_start <= (next_state == ST_SOFT);
      o_hiccup     <= (next_state == ST_HICCUP);
    end
  end

  assign o_output_valid_flag = valid;

endmodule : buck_fault_hiccup_sequencer

/* File: buck_seq_pkg.sv */
package buck_seq_pkg;

  localparam int CLK_MHZ            = 200;
  localparam int UV_FILT_NS         = 2000;
  localparam int OV_FILT_NS         = 1000;
  localparam int NEG_HOLD_NS        = 640;
  localparam int VALID_DLY_US       = 100;
  // Least times, rounded up to whole cycles
  localparam int UV_FILT_CYC        = (UV_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int OV_FILT_CYC        = (OV_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int NEG_HOLD_CYC       = (NEG_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int VALID_DLY_CYC      = VALID_DLY_US * CLK_MHZ;
  localparam int DUTY_MAX_PCT       = 80;
  localparam int SW_PERIOD_CYC_DEF  = 364;
  localparam int SS_CYC_DEF         = 200000;
  localparam int RST_CYC_DEF        = 2000;
  localparam int BOOT_CYC_DEF       = 400;

  localparam logic [3:0] OC_ADD     = 4'h2;
  localparam logic [3:0] OC_SUB     = 4'h1;
  localparam logic [3:0] HS_OC_TRIP = 4'h6;
  localparam logic [3:0] LS_OC_TRIP = 4'h8;
  localparam logic [3:0] HICCUP_HS  = 4'h6;
  localparam logic [3:0] HICCUP_LS  = 4'h4;
  localparam logic [3:0] HICCUP_UV  = 4'h5;
  localparam logic [3:0] HICCUP_OV  = 4'h8;

  typedef enum logic [9:0] {
    ST_OFF     = 10'h001,
    ST_LOCKOUT = 10'h002,
    ST_RST     = 10'h004,
    ST_BOOT    = 10'h008,
    ST_SOFT    = 10'h010,
    ST_RUN     = 10'h020,
    ST_DRAIN   = 10'h040,
    ST_HICCUP  = 10'h080,
    ST_THERMAL = 10'h100,
    ST_SPARE   = 10'h200
  } seq_state_t;

  typedef struct packed {
    logic enable;
    logic supply_ok;
    logic pwm_off;
    logic hs_limit;
    logic ls_limit;
    logic ls_neg_limit;
    logic zero_current;
    logic fb_under;
    logic fb_over;
    logic fb_in_window;
    logic over_temp;
    logic temp_recovered;
  } analog_in_t;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } gate_t;

endpackage : buck_seq_pkg

/* File: buck_fault_hiccup_sequencer_props.sv */
`timescale 1ns/1ps
module buck_fault_hiccup_sequencer_props
  import buck_seq_pkg::*;
#(
  parameter int SW_PERIOD_CYC = 20,
  parameter int SS_CYC        = 64,
  parameter int VALID_CYC     = 16
) (
  input wire logic       i_ref_clk,
  input wire logic       i_rstn,
  input wire analog_in_t i_analog,
  input wire gate_t      o_gate,
  input wire logic       o_output_valid_flag,
  input wire logic       o_ref_zero,
  input wire logic       o_soft_start,
  input wire logic       o_hiccup
);
  localparam int DUTY = SW_PERIOD_CYC * DUTY_MAX_PCT / 100;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  int hs_run = 0;
  int win    = 0;
  int ovc    = 0;
  int hic    = 0;
  // Raw counts run ahead of the synchronized ones, so they bound them
  always_ff @(posedge i_ref_clk) begin
    hs_run <= o_gate.hs_on ? hs_run + 1 : 0;
    win    <= i_analog.fb_in_window ? win + 1 : 0;
    ovc    <= i_analog.fb_over ? ovc + 1 : 0;
    hic    <= o_hiccup ? hic + 1 : 0;
  end
  property p_overlap;
    !(o_gate.hs_on && o_gate.ls_on);
  endproperty
  a_overlap: assert property (p_overlap) else $error("both switches on");
  property p_duty;
    o_gate.hs_on |-> hs_run < DUTY;
  endproperty
  a_duty: assert property (p_duty) else $error("on-time above duty cap");
  property p_hs_limit;
    i_analog.hs_limit [*4] |=> !o_gate.hs_on;
  endproperty
  a_hs_limit: assert property (p_hs_limit) else $error("on-time not cut by limit");
  property p_ov_out;
    o_ref_zero |-> !o_output_valid_flag && !o_gate.hs_on;
  endproperty
  a_ov_out: assert property (p_ov_out) else $error("overvoltage outputs wrong");
  property p_ov_filt;
    $rose(o_ref_zero) |-> ovc >= OV_FILT_CYC;
  endproperty
  a_ov_filt: assert property (p_ov_filt) else $error("overvoltage filter too short");
  property p_valid_win;
    $rose(o_output_valid_flag) |-> win >= VALID_CYC;
  endproperty
  a_valid_win: assert property (p_valid_win) else $error("valid flag too early");
  property p_hic_hs;
    o_hiccup |-> !o_gate.hs_on && !o_soft_start;
  endproperty
  a_hic_hs: assert property (p_hic_hs) else $error("switching in hiccup");
  property p_hic_min;
    $fell(o_hiccup) |-> hic >= 4 * SS_CYC;
  endproperty
  a_hic_min: assert property (p_hic_min) else $error("hiccup too short");
  property p_thermal;
    (o_soft_start && i_analog.over_temp) [*4] |-> ##[1:3] (!o_gate.hs_on && !o_gate.ls_on && !o_soft_start);
  endproperty
  a_thermal: assert property (p_thermal) else $error("thermal trip ignored");
  c_ov: cover property ($rose(o_ref_zero));
  c_hic: cover property ($fell(o_hiccup));
  c_valid: cover property ($rose(o_output_valid_flag));
endmodule : buck_fault_hiccup_sequencer_props

bind buck_fault_hiccup_sequencer buck_fault_hiccup_sequencer_props #(
  .SW_PERIOD_CYC(SW_PERIOD_CYC), .SS_CYC(SS_CYC), .VALID_CYC(VALID_CYC)
) props_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_analog(i_analog), .o_gate(o_gate),
  .o_output_valid_flag(o_output_valid_flag), .o_ref_zero(o_ref_zero), .o_soft_start(o_soft_start),
  .o_hiccup(o_hiccup));

/* File: buck_stage_model.sv */
`timescale 1ns/1ps
module buck_stage_model
  import buck_seq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire gate_t      i_gate,
  input  wire analog_in_t i_cmd,
  output analog_in_t      o_sense
);
  int on_cnt = 0;
  int ls_cnt = 0;
  always_ff @(posedge i_clk) begin
    on_cnt <= i_gate.hs_on ? on_cnt + 1 : 0;
    ls_cnt <= (i_gate.ls_on && !i_gate.hs_on) ? ls_cnt + 1 : 0;
  end
  // Zero current only after a long freewheel, never in a normal off-time
  always_comb begin
    o_sense              = i_cmd;
    o_sense.pwm_off      = i_cmd.pwm_off | (on_cnt >= 6);
    o_sense.zero_current = i_cmd.zero_current | (ls_cnt >= 16);
  end
endmodule : buck_stage_model

/* File: test_buck_fault_hiccup_sequencer.sv */
`timescale 1ns/1ps
module test_buck_fault_hiccup_sequencer;
  import buck_seq_pkg::*;
  localparam int SS = 64;
  logic       i_ref_clk = 1'b0;
  logic       i_rstn    = 1'b0;
  analog_in_t cmd       = '0;
  analog_in_t i_analog;
  gate_t      o_gate;
  logic       o_output_valid_flag;
  logic       o_ref_zero;
  logic       o_soft_start;
  logic       o_hiccup;
  int         failures  = 0;
  int         compares  = 0;
  int         seed      = 32'hfc888ed2;
  int         exp_q[$];
  int         mult[4]   = '{6, 4, 5, 8};

  always #2.5 i_ref_clk = ~i_ref_clk;

  buck_fault_hiccup_sequencer #(.SW_PERIOD_CYC(20), .SS_CYC(SS), .RST_CYC(8), .BOOT_CYC(8), .VALID_CYC(16))
  buck_fault_hiccup_sequencer_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_analog(i_analog), .o_gate(o_gate),
    .o_output_valid_flag(o_output_valid_flag), .o_ref_zero(o_ref_zero), .o_soft_start(o_soft_start),
    .o_hiccup(o_hiccup));
  buck_stage_model buck_stage_model_i (.i_clk(i_ref_clk), .i_gate(o_gate), .i_cmd(cmd), .o_sense(i_analog));

  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(string what, int exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %0d got %0d", what, exp, got);
    end
  endtask : chk

  task automatic wait_lvl(int k, logic lvl, int lim, output int c);
    logic [4:0] v;
    c = 0;
    v = {o_gate.ls_on, o_hiccup, o_soft_start, o_output_valid_flag, o_ref_zero};
    while (v[k] !== lvl && c < lim) begin
      @(posedge i_ref_clk);
      c++;
      v = {o_gate.ls_on, o_hiccup, o_soft_start, o_output_valid_flag, o_ref_zero};
    end
    if (c >= lim) begin
      failures++;
      $display("MISMATCH wait %0d exp %0d got timeout", k, lvl);
      summarize();
    end
  endtask : wait_lvl

  initial begin : main
    int      c;
    logic    seen;
    realtime t0;
    repeat (6) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    chk("reset outs", 0, {o_gate, o_output_valid_flag, o_soft_start, o_hiccup});
    cmd.enable <= 1'b1;
    cmd.supply_ok <= 1'b1;
    cmd.fb_in_window <= 1'b1;
    wait_lvl(2, 1'b1, 100, c);
    wait_lvl(2, 1'b0, 2 * SS, c);
    chk("soft len", SS, c);
    wait_lvl(1, 1'b1, 100, c);
    $display("test startup done");
    // Glitches shorter than the filter must not trip
    repeat (5) begin
      c = 1 + ($unsigned($random(seed)) % 300);
      cmd.fb_under <= 1'b1;
      repeat (c) @(posedge i_ref_clk);
      cmd.fb_under <= 1'b0;
      repeat (40) @(posedge i_ref_clk);
      chk("uv glitch", 2, {o_output_valid_flag, o_hiccup});
    end
    for (int k = 0; k < 4; k++) begin
      exp_q.push_back(mult[k] * SS);
      case (k)
        0: cmd.hs_limit <= 1'b1;
        1: cmd.ls_limit <= 1'b1;
        2: cmd.fb_under <= 1'b1;
        default: cmd.fb_over <= 1'b1;
      endcase
      if (k == 1) begin
        repeat (25) @(posedge i_ref_clk);
        seen = 1'b0;
        repeat (20) begin
          @(posedge i_ref_clk);
          seen = seen | o_gate.hs_on;
        end
        chk("ls skip", 0, seen);
      end
      wait_lvl(3, 1'b1, 2000, c);
      t0 = $realtime;
      @(posedge i_ref_clk);
      chk("fault valid", 0, o_output_valid_flag);
      chk("ref zero", k == 3, o_ref_zero);
      chk("hs off", 0, o_gate.hs_on);
      if (k == 3) begin
        chk("ov ls", 1, o_gate.ls_on);
        cmd.ls_neg_limit <= 1'b1;
        @(posedge i_ref_clk);
        cmd.ls_neg_limit <= 1'b0;
        wait_lvl(4, 1'b0, 10, c);
        wait_lvl(4, 1'b1, 400, c);
        chk("neg hold", 1, c >= NEG_HOLD_CYC);
      end
      // Drop hs, ls, under and over fault levels together
      cmd <= cmd & ~12'h198;
      wait_lvl(3, 1'b0, 9 * SS, c);
      chk("hiccup len", exp_q.pop_front(), int'(($realtime - t0) / 5.0));
      @(posedge i_ref_clk);
      chk("boot ls", 1, o_gate.ls_on);
      wait_lvl(2, 1'b1, 30, c);
      wait_lvl(2, 1'b0, 2 * SS, c);
      chk("resoft len", SS, c);
      wait_lvl(1, 1'b1, 100, c);
      $display("test fault %0d done", k);
    end
    cmd.over_temp <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("thermal off", 0, {o_gate, o_soft_start, o_output_valid_flag});
    cmd.over_temp <= 1'b0;
    cmd.temp_recovered <= 1'b1;
    wait_lvl(2, 1'b1, 7, c);
    cmd.temp_recovered <= 1'b0;
    $display("test thermal done");
    wait_lvl(2, 1'b0, 2 * SS, c);
    cmd.supply_ok <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk("lockout", 0, {o_gate.hs_on, o_soft_start, o_output_valid_flag});
    cmd.supply_ok <= 1'b1;
    wait_lvl(2, 1'b1, 40, c);
    chk("boot wait", 1, c >= 8);
    $display("test lockout done");
    summarize();
  end
endmodule : test_buck_fault_hiccup_sequencer
